// ### maint_chan_ctrl.sv
// Maintenance channel control: eoc and M4 filtering, transparency, timer
`timescale 1ns/1ns

module maint_chan_ctrl
  import maint_chan_pkg::*;
#(
  parameter longint ACT_TIMEOUT = ACT_TIMEOUT_CYC
)
(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address
  input  wire logic [31:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [31:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Deframer side
  input  wire logic              sf_sync,
  input  wire logic              rx_eoc_valid,
  input  wire logic [EOC_W-1:0]  rx_eoc_word,
  input  wire logic              rx_m4_valid,
  input  wire logic [M4_W-1:0]   rx_m4_bits,
  // Framer side
  input  wire logic              tx_eoc_boundary,
  input  wire logic [3:0]        framer_state,
  output logic [EOC_W-1:0]       tx_eoc_word,
  output logic [M4_W-1:0]        tx_m4_bits,
  output logic                   framer_hold_sn2,
  // Activation and deactivation
  input  wire logic              act_in_progress,
  input  wire logic              full_active,
  output logic                   act_abort,
  output logic                   controlled_deact,
  output logic                   warm_start,
  // Customer data path control
  input  wire logic              pcm_frame_sync,
  output logic                   customer_transparent,
  // Interrupt
  output logic                   irq
);

  // ==========================================================
  // Elaboration checks; the counter below is only 32 bits wide
  if (ACT_TIMEOUT < 1 || ACT_TIMEOUT > 64'h00000000ffffffff)
  begin : g_bad_timeout
    $error("ACT_TIMEOUT must fit in 32 bits and be nonzero");
  end

  // ==========================================================
  // Register state
  logic [EOC_W-1:0] eoc_tx;
  logic [EOC_W-1:0] eoc_rx;
  logic [M4_W-1:0]  m4_tx;
  logic [M4_W-1:0]  m4_rx;
  logic [3:0]       fs_hold;
  logic [1:0]       eoc_ctl;
  logic [1:0]       m4_ctl;
  logic             timer_dis;
  logic [7:0]       link_ctrl;
  logic [7:0]       irq_en;
  logic [7:0]       option;
  logic             eoc_flag;
  logic             m4_flag;
  logic             verified_act;
  logic             verified_dea;
  logic             err_ind;

  // ==========================================================
  // AXI4-Lite slave
  logic        aw_held;
  logic        w_held;
  logic [5:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_go;
  logic [31:0] rd_val;
  logic        rd_ok;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go         = aw_held && w_held && !s_axi_bvalid;

  // Address and data are latched independently, in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 6'h00;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[5:2], 2'b00};
      end
      else if (wr_go)
        aw_held <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (wr_go)
        w_held <= 1'b0;
    end
  end

  // Write response, SLVERR for unmapped offsets
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr <= OFF_IRQ_STAT) ? 2'b00 : 2'b10;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Read mux; reserved bits read as zero
  always_comb
  begin
    rd_val = 32'h00000000;
    rd_ok  = 1'b1;
    case ({s_axi_araddr[5:2], 2'b00})
      OFF_EOC:        rd_val[EOC_W-1:0] = eoc_rx;
      OFF_M4_TX:      rd_val[7:0] = m4_tx;
      OFF_M4_RX:      rd_val[7:0] = m4_rx;
      OFF_VERIFIED:   rd_val[7:0] = {5'h00, verified_act, verified_dea, 1'b0};
      OFF_FRAMER:     rd_val[FS_HI:FS_LO] = framer_state;
      OFF_MAINT_MODE: rd_val[7:0] = {eoc_ctl, m4_ctl, 4'h0};
      OFF_TIMER:      rd_val[TMR_DIS_B] = timer_dis;
      OFF_LINK_STAT:  rd_val[7:0] = {5'h00, err_ind, sf_sync, act_in_progress};
      OFF_LINK_CTRL:  rd_val[7:0] = link_ctrl;
      OFF_IRQ_EN:     rd_val[7:0] = irq_en;
      OFF_OPTION:     rd_val[7:0] = option;
      OFF_IRQ_STAT:   rd_val[7:0] = {5'h00, eoc_flag, m4_flag, 1'b0};
      default:        rd_ok = 1'b0;
    endcase
  end

  // Read data registered, held until rready
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'b00;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ==========================================================
  // Control registers written by software (lane 0 strobe only; eoc takes bits 11:0)
  logic wr_lo;
  assign wr_lo = wr_go && w_strb[0];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      eoc_tx    <= EOC_TX_RST;
      m4_tx     <= M4_TX_RST;
      fs_hold   <= FS_RELEASE;
      eoc_ctl   <= 2'b00;
      m4_ctl    <= 2'b00;
      timer_dis <= 1'b0;
      link_ctrl <= 8'h00;
      irq_en    <= 8'h00;
      option    <= 8'h00;
    end
    else if (wr_lo)
    begin
      case (aw_addr)
        OFF_EOC:        eoc_tx <= w_data[EOC_W-1:0];
        OFF_M4_TX:      m4_tx <= w_data[7:0];
        OFF_FRAMER:     fs_hold <= w_data[FS_HI:FS_LO];
        OFF_MAINT_MODE:
        begin
          eoc_ctl <= w_data[EOC_CTL_HI:EOC_CTL_LO];
          m4_ctl  <= w_data[M4_CTL_HI:M4_CTL_LO];
        end
        OFF_TIMER:      timer_dis <= w_data[TMR_DIS_B];
        OFF_LINK_CTRL:  link_ctrl <= w_data[7:0];
        OFF_IRQ_EN:     irq_en <= w_data[7:0];
        OFF_OPTION:     option <= w_data[7:0];
        default:        ;
      endcase
    end
  end

  // Hold value A keeps the framer in SN2; anything else releases
  assign framer_hold_sn2 = (fs_hold == FS_HOLD_SN2);
  assign tx_m4_bits      = m4_tx;

  // Host eoc word goes out at the next eoc frame boundary unless the auto eoc option bit is set
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tx_eoc_word <= EOC_TX_RST;
    else if (tx_eoc_boundary && !option[AUTO_EOC_B])
      tx_eoc_word <= eoc_tx;
  end

  // ==========================================================
  // Received eoc filtering, two frames per superframe
  logic [EOC_W-1:0] eoc_p1;
  logic [EOC_W-1:0] eoc_p2;
  logic [1:0]       eoc_hist;
  logic             eoc_upd;

  always_comb
  begin
    eoc_upd = 1'b0;
    if (rx_eoc_valid && sf_sync)
    begin
      case (eoc_mode_t'(eoc_ctl))
        EOC_TRINAL: eoc_upd = (eoc_hist == 2'd2) && (rx_eoc_word == eoc_p1)
                              && (eoc_p1 == eoc_p2) && (rx_eoc_word != eoc_rx);
        EOC_DUAL:   eoc_upd = (eoc_hist != 2'd0) && (rx_eoc_word == eoc_p1)
                              && (rx_eoc_word != eoc_rx);
        EOC_DELTA:  eoc_upd = (rx_eoc_word != eoc_rx);
        EOC_EVERY:  eoc_upd = 1'b1;
        default:    eoc_upd = 1'b0;
      endcase
    end
  end

  // History restarts when sync drops; register holds its value
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !sf_sync)
    begin
      eoc_p1   <= '0;
      eoc_p2   <= '0;
      eoc_hist <= 2'd0;
    end
    else if (rx_eoc_valid)
    begin
      eoc_p1   <= rx_eoc_word;
      eoc_p2   <= eoc_p1;
      eoc_hist <= (eoc_hist == 2'd2) ? 2'd2 : eoc_hist + 2'd1;
    end
  end

  // Updated in every mode, automatic processing included
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      eoc_rx <= EOC_TX_RST;
    else if (eoc_upd)
      eoc_rx <= rx_eoc_word;
  end

  // ==========================================================
  // Received M4 filtering, one bit at a time
  logic [M4_W-1:0] m4_p1;
  logic [M4_W-1:0] m4_p2;
  logic [1:0]      m4_hist;
  logic [M4_W-1:0] next_m4_rx;
  logic            m4_take;
  logic            m4_upd;

  assign m4_take = rx_m4_valid && sf_sync;

  for (genvar b = 0; b < M4_W; b++)
  begin : g_m4_bit
    logic dual_ok;
    logic tri_ok;
    assign dual_ok = (m4_hist != 2'd0) && (rx_m4_bits[b] == m4_p1[b]);
    assign tri_ok  = (m4_hist == 2'd2) && (rx_m4_bits[b] == m4_p1[b])
                     && (m4_p1[b] == m4_p2[b]);
    always_comb
    begin
      next_m4_rx[b] = m4_rx[b];
      if (option[M4_TRI_B] && M4_TRINAL_MASK[b])
      begin
        if (tri_ok)
          next_m4_rx[b] = rx_m4_bits[b];
      end
      else
      begin
        case (m4_mode_t'(m4_ctl))
          M4_DUAL_VERIFY: if (dual_ok) next_m4_rx[b] = rx_m4_bits[b];
          M4_DUAL:        if (dual_ok) next_m4_rx[b] = rx_m4_bits[b];
          M4_DELTA:       next_m4_rx[b] = rx_m4_bits[b];
          M4_EVERY:       next_m4_rx[b] = rx_m4_bits[b];
          default:        next_m4_rx[b] = m4_rx[b];
        endcase
      end
    end
  end

  // Every-frame mode reports even an unchanged value
  assign m4_upd = m4_take && ((m4_mode_t'(m4_ctl) == M4_EVERY)
                  || (next_m4_rx != m4_rx));

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !sf_sync)
    begin
      m4_p1   <= '0;
      m4_p2   <= '0;
      m4_hist <= 2'd0;
    end
    else if (rx_m4_valid)
    begin
      m4_p1   <= rx_m4_bits;
      m4_p2   <= m4_p1;
      m4_hist <= (m4_hist == 2'd2) ? 2'd2 : m4_hist + 2'd1;
    end
  end

  // Verified flags follow the register only in mode 0,0
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      m4_rx        <= M4_RX_RST;
      verified_act <= 1'b0;
      verified_dea <= 1'b0;
    end
    else
    begin
      if (m4_upd)
        m4_rx <= next_m4_rx;
      if (m4_mode_t'(m4_ctl) != M4_DUAL_VERIFY)
      begin
        verified_act <= 1'b0;
        verified_dea <= 1'b0;
      end
      else if (m4_upd)
      begin
        verified_act <= next_m4_rx[ACT_B];
        verified_dea <= link_ctrl[NT_ROLE_B] && !next_m4_rx[DEA_B];
      end
    end
  end

  // ==========================================================
  // Transparency: only B and D are gated, M bits always pass
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      customer_transparent <= 1'b0;
    else if (pcm_frame_sync)
      customer_transparent <= verified_act || link_ctrl[CUST_EN_B];
  end

  // ==========================================================
  // NT deactivation on dea = 0, remembered for warm restart
  logic deact_cond;
  assign deact_cond = link_ctrl[NT_ROLE_B] && !m4_rx[DEA_B]
                      && (verified_dea || link_ctrl[DEACT_RQ_B]);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      controlled_deact <= 1'b0;
      warm_start       <= 1'b0;
    end
    else
    begin
      controlled_deact <= deact_cond;
      if (deact_cond)
        warm_start <= 1'b1;
      else if (full_active)
        warm_start <= 1'b0;
    end
  end

  // ==========================================================
  // Activation timer; a disabled timer simply stops counting
  logic        aip_d;
  logic [31:0] act_cnt;
  logic        act_run;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aip_d     <= 1'b0;
      act_cnt   <= 32'h00000000;
      act_run   <= 1'b0;
      act_abort <= 1'b0;
      err_ind   <= 1'b0;
    end
    else
    begin
      aip_d     <= act_in_progress;
      act_abort <= 1'b0;
      if (act_in_progress && !aip_d)
      begin
        act_run <= 1'b1;
        act_cnt <= 32'h00000000;
        err_ind <= 1'b0;
      end
      else if (!act_in_progress || full_active)
        act_run <= 1'b0;
      else if (act_run && !timer_dis)
      begin
        if (act_cnt == 32'(ACT_TIMEOUT - 1))
        begin
          act_run   <= 1'b0;
          act_abort <= 1'b1;
          err_ind   <= 1'b1;
        end
        else
          act_cnt <= act_cnt + 32'h00000001;
      end
    end
  end

  // ==========================================================
  // Sticky update flags, write one to clear; a new event wins
  logic clr_lo;
  assign clr_lo = wr_lo && (aw_addr == OFF_IRQ_STAT);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      eoc_flag <= 1'b0;
      m4_flag  <= 1'b0;
    end
    else
    begin
      if (eoc_upd)
        eoc_flag <= 1'b1;
      else if (clr_lo && w_data[IRQ_EOC_B])
        eoc_flag <= 1'b0;
      if (m4_upd)
        m4_flag <= 1'b1;
      else if (clr_lo && w_data[IRQ_M4_B])
        m4_flag <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= (eoc_flag && irq_en[IRQ_EOC_B])
             || (m4_flag && irq_en[IRQ_M4_B]);
  end

endmodule // maint_chan_ctrl

// ### maint_chan_pkg.sv
// Constants shared by the maintenance channel control block
package maint_chan_pkg;

  // ==========================================================
  // Register byte offsets (AXI4-Lite, one aligned word each)
  localparam logic [5:0] OFF_EOC        = 6'h00;
  localparam logic [5:0] OFF_M4_TX      = 6'h04;
  localparam logic [5:0] OFF_M4_RX      = 6'h08;
  localparam logic [5:0] OFF_VERIFIED   = 6'h0c;
  localparam logic [5:0] OFF_FRAMER     = 6'h10;
  localparam logic [5:0] OFF_MAINT_MODE = 6'h14;
  localparam logic [5:0] OFF_TIMER      = 6'h18;
  localparam logic [5:0] OFF_LINK_STAT  = 6'h1c;
  localparam logic [5:0] OFF_LINK_CTRL  = 6'h20;
  localparam logic [5:0] OFF_IRQ_EN     = 6'h24;
  localparam logic [5:0] OFF_OPTION     = 6'h28;
  localparam logic [5:0] OFF_IRQ_STAT   = 6'h2c;

  // ==========================================================
  // Superframe layout: 48 maintenance bits, six subchannels of 8
  localparam int M_BITS_PER_SF   = 48;
  localparam int SUBCH_BITS      = 8;
  localparam int EOC_SUBCH       = 3;
  // Two eoc frames per superframe, one at each half
  localparam int EOC_W           = EOC_SUBCH * SUBCH_BITS / 2;
  localparam int M4_W            = SUBCH_BITS;

  // ==========================================================
  // Field positions
  localparam int FS_HI = 7;          // framer state field
  localparam int FS_LO = 4;
  localparam logic [3:0] FS_HOLD_SN2 = 4'ha;
  localparam logic [3:0] FS_RELEASE  = 4'h0;
  localparam int EOC_CTL_HI = 7;
  localparam int EOC_CTL_LO = 6;
  localparam int M4_CTL_HI  = 5;
  localparam int M4_CTL_LO  = 4;
  localparam int TMR_DIS_B  = 0;
  localparam int CUST_EN_B  = 0;
  localparam int DEACT_RQ_B = 2;
  localparam int NT_ROLE_B  = 4;
  localparam int IRQ_M4_B   = 1;
  localparam int IRQ_EOC_B  = 2;
  localparam int M4_TRI_B   = 0;
  localparam int AUTO_EOC_B = 3;
  localparam int VER_ACT_B  = 2;
  localparam int VER_DEA_B  = 1;
  localparam int ST_AIP_B   = 0;
  localparam int ST_SYNC_B  = 1;
  localparam int ST_ERR_B   = 2;
  localparam int ACT_B      = 7;     // M4 act position
  localparam int DEA_B      = 6;     // M4 dea position
  // act, dea, sai, uoa positions checked by trinal option
  localparam logic [7:0] M4_TRINAL_MASK = 8'hf0;

  // ==========================================================
  // Reset values
  localparam logic [11:0] EOC_TX_RST = 12'hfff;
  localparam logic [7:0]  M4_TX_RST  = 8'hff;
  localparam logic [7:0]  M4_RX_RST  = 8'hff;

  // ==========================================================
  // Update filter modes (eoc and M4 control fields)
  typedef enum logic [1:0] {
    M4_DUAL_VERIFY = 2'b00,
    M4_DUAL        = 2'b01,
    M4_DELTA       = 2'b10,
    M4_EVERY       = 2'b11
  } m4_mode_t;

  typedef enum logic [1:0] {
    EOC_TRINAL = 2'b00,
    EOC_DUAL   = 2'b01,
    EOC_DELTA  = 2'b10,
    EOC_EVERY  = 2'b11
  } eoc_mode_t;

  // ==========================================================
  // Timing
  localparam longint CLK_HZ          = 100_000_000;
  localparam longint ACT_TIMEOUT_S   = 15;
  localparam longint ACT_TIMEOUT_CYC = ACT_TIMEOUT_S * CLK_HZ;

endpackage

// ### maint_chan_asserts.sv
// Concurrent checks on the maintenance channel control ports
`timescale 1ns/1ns
module maint_chan_asserts
  import maint_chan_pkg::*;
#(
  parameter longint ACT_TIMEOUT = 20
)
(
  // Clock, reset and bus
  input wire logic             aclk,
  input wire logic             aresetn,
  input wire logic             s_axi_bvalid,
  // Deframer and framer side
  input wire logic             sf_sync,
  input wire logic             rx_eoc_valid,
  input wire logic             rx_m4_valid,
  input wire logic             tx_eoc_boundary,
  input wire logic [EOC_W-1:0] tx_eoc_word,
  input wire logic [M4_W-1:0]  tx_m4_bits,
  input wire logic             framer_hold_sn2,
  // Activation and data path
  input wire logic             act_in_progress,
  input wire logic             act_abort,
  input wire logic             controlled_deact,
  input wire logic             warm_start,
  input wire logic             pcm_frame_sync,
  input wire logic             customer_transparent,
  input wire logic             irq
);
  longint aip_cnt;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ==========================================================
  // Cycles in activation; a pause only lengthens the real wait
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !act_in_progress)
      aip_cnt <= 0;
    else
      aip_cnt <= aip_cnt + 1;
  end

  // ==========================================================
  // Port relations
  a_hold_sn2_write: assert property ($changed(framer_hold_sn2) |-> ##[0:1] s_axi_bvalid)
    else $error("hold output moved without a write");
  a_eoc_at_boundary: assert property ($changed(tx_eoc_word) |-> $past(tx_eoc_boundary))
    else $error("eoc word loaded off the boundary");
  a_m4_tx_write: assert property ($changed(tx_m4_bits) |-> ##[0:1] s_axi_bvalid)
    else $error("M4 transmit bits moved without a write");
  a_pass_at_frame: assert property ($changed(customer_transparent) |-> $past(pcm_frame_sync))
    else $error("transparency changed off a frame boundary");
  a_warm_with_deact: assert property ($rose(warm_start) |-> controlled_deact)
    else $error("warm start without deactivation");
  a_abort_one_cycle: assert property (act_abort |=> !act_abort)
    else $error("abort longer than one cycle");
  a_abort_after_timeout: assert property (act_abort |-> aip_cnt >= ACT_TIMEOUT - 1)
    else $error("abort before the timeout ran out");
  a_irq_has_cause: assert property ($rose(irq) |-> s_axi_bvalid || $past(s_axi_bvalid)
    || $past(sf_sync, 2) && ($past(rx_eoc_valid, 2) || $past(rx_m4_valid, 2)))
    else $error("interrupt without a synced update");
endmodule // maint_chan_asserts

bind maint_chan_ctrl maint_chan_asserts #(.ACT_TIMEOUT(ACT_TIMEOUT)) maint_chan_asserts_i (
  .aclk, .aresetn, .s_axi_bvalid, .sf_sync, .rx_eoc_valid, .rx_m4_valid, .tx_eoc_boundary,
  .tx_eoc_word, .tx_m4_bits, .framer_hold_sn2, .act_in_progress, .act_abort,
  .controlled_deact, .warm_start, .pcm_frame_sync, .customer_transparent, .irq);

// ### far_end_model.sv
// Behavioural framer and deframer facing the remote transceiver
`timescale 1ns/1ns
module far_end_model
  import maint_chan_pkg::*;
(
  // Clock
  input  wire logic       aclk,
  // Deframer outputs
  output logic             sf_sync,
  output logic             rx_eoc_valid,
  output logic [EOC_W-1:0] rx_eoc_word,
  output logic             rx_m4_valid,
  output logic [M4_W-1:0]  rx_m4_bits,
  // Framer and PCM timing
  output logic             tx_eoc_boundary,
  output logic [3:0]       framer_state,
  output logic             pcm_frame_sync
);
  logic [3:0] tick;

  // ==========================================================
  // Idle values at time zero
  initial
  begin
    tick = 4'h0;
    sf_sync = 1'b0;
    rx_eoc_valid = 1'b0;
    rx_eoc_word = 12'h000;
    rx_m4_valid = 1'b0;
    rx_m4_bits = 8'h00;
    tx_eoc_boundary = 1'b0;
    framer_state = 4'h0;
    pcm_frame_sync = 1'b0;
  end

  // Free-running eoc boundary and PCM frame pulses
  always @(posedge aclk)
  begin
    tick <= tick + 4'h1;
    tx_eoc_boundary <= (tick == 4'hf);
    pcm_frame_sync <= (tick[2:0] == 3'h7);
  end

  // Sync level and framer state
  task automatic set(input logic s, input logic [3:0] f);
    @(posedge aclk);
    sf_sync <= s;
    framer_state <= f;
  endtask

  // One M4 byte per superframe; bits invert once the strobe drops
  task automatic m4(input logic [M4_W-1:0] b);
    @(posedge aclk);
    rx_m4_bits <= b;
    rx_m4_valid <= 1'b1;
    @(posedge aclk);
    rx_m4_valid <= 1'b0;
    rx_m4_bits <= ~b;
  endtask

  // One eoc frame, half of the three eoc subchannels
  task automatic eoc(input logic [EOC_W-1:0] w);
    @(posedge aclk);
    rx_eoc_word <= w;
    rx_eoc_valid <= 1'b1;
    @(posedge aclk);
    rx_eoc_valid <= 1'b0;
    rx_eoc_word <= ~w;
  endtask
endmodule // far_end_model

// ### test_maint_chan_ctrl.sv
// Register-level tests of the maintenance channel control block
`timescale 1ns/1ns
module test_maint_chan_ctrl;
  import maint_chan_pkg::*;
  logic             aclk = 1'b0;
  logic             aresetn = 1'b0;
  logic [31:0]      s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]       s_axi_wstrb, framer_state;
  logic [1:0]       s_axi_bresp, s_axi_rresp;
  logic             s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic             s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic             s_axi_rvalid, s_axi_rready, sf_sync, rx_eoc_valid, rx_m4_valid;
  logic [EOC_W-1:0] rx_eoc_word, tx_eoc_word;
  logic [M4_W-1:0]  rx_m4_bits, tx_m4_bits;
  logic             tx_eoc_boundary, framer_hold_sn2, act_in_progress, full_active;
  logic             act_abort, controlled_deact, warm_start, pcm_frame_sync;
  logic             customer_transparent, irq;
  int               n_errors = 0;
  int               total_checks = 0;
  logic [1:0]       mode [4] = '{2'b11, 2'b10, 2'b01, 2'b00};
  logic [7:0]       val [4] = '{8'h11, 8'h22, 8'h33, 8'hc4};
  logic [7:0]       first [4] = '{8'h11, 8'h22, 8'h22, 8'h33};

  maint_chan_ctrl #(.ACT_TIMEOUT(20)) maint_chan_ctrl_i (.*);
  far_end_model far_end_model_i (.*);

  // 100 MHz clock
  always #5 aclk = ~aclk;

  // ==========================================================
  // Checking and ending
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    if (n_errors == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // ==========================================================
  // AXI4-Lite master; both halves offered together
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bit ad;
    bit wd;
    ad = 0;
    wd = 0;
    @(posedge aclk);
    s_axi_awaddr <= {26'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd))
    begin
      @(posedge aclk);
      if (!ad && s_axi_awready)
      begin
        ad = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready)
      begin
        wd = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rdreg(input logic [5:0] a, input logic [31:0] exp);
    @(posedge aclk);
    s_axi_araddr <= {26'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, exp);
    chk(32'(s_axi_rresp), (a > OFF_IRQ_STAT) ? 32'h2 : 32'h0);
  endtask

  // Hang guard, well beyond the expected few hundred cycles
  initial
  begin
    cyc(20000);
    n_errors++;
    wrap_up;
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    s_axi_awaddr = 32'h0;
    s_axi_wdata = 32'h0;
    s_axi_araddr = 32'h0;
    s_axi_wstrb = 4'h1;
    act_in_progress = 1'b0;
    full_active = 1'b0;
    cyc(2);
    aresetn <= 1'b1;
    rdreg(OFF_EOC, 32'hfff);
    rdreg(OFF_M4_TX, 32'hff);
    rdreg(6'h30, 32'h0);
    far_end_model_i.set(1'b1, 4'h5);
    rdreg(OFF_FRAMER, 32'h50);
    wr(OFF_FRAMER, 32'ha0);
    chk(32'(framer_hold_sn2), 32'h1);
    wr(OFF_FRAMER, 32'h00);
    chk(32'(framer_hold_sn2), 32'h0);
    // Act bit first, then customer enable
    wr(OFF_M4_TX, 32'h80);
    chk(32'(tx_m4_bits), 32'h80);
    // Lane 0 strobe off: the write must not land
    s_axi_wstrb <= 4'h0;
    wr(OFF_M4_TX, 32'h00);
    chk(32'(tx_m4_bits), 32'h80);
    s_axi_wstrb <= 4'h1;
    wr(OFF_LINK_CTRL, 32'h1);
    cyc(10);
    chk(32'(customer_transparent), 32'h1);
    wr(OFF_LINK_CTRL, 32'h0);
    cyc(10);
    chk(32'(customer_transparent), 32'h0);
    wr(OFF_EOC, 32'h5a5);
    @(posedge tx_eoc_boundary);
    cyc(2);
    chk(32'(tx_eoc_word), 32'h5a5);
    // Every M4 mode, same byte twice
    wr(OFF_IRQ_EN, 32'h2);
    for (int i = 0; i < 4; i++)
    begin
      wr(OFF_MAINT_MODE, {26'h0, mode[i], 4'h0});
      far_end_model_i.m4(val[i]);
      rdreg(OFF_M4_RX, {24'h0, first[i]});
      far_end_model_i.m4(val[i]);
      rdreg(OFF_M4_RX, {24'h0, val[i]});
    end
    rdreg(OFF_VERIFIED, 32'h4);
    cyc(10);
    chk(32'(customer_transparent), 32'h1);
    chk(32'(irq), 32'h1);
    rdreg(OFF_IRQ_STAT, 32'h2);
    wr(OFF_IRQ_STAT, 32'h2);
    cyc(2);
    chk(32'(irq), 32'h0);
    // Updates frozen without sync
    wr(OFF_MAINT_MODE, 32'h30);
    far_end_model_i.set(1'b0, 4'h5);
    far_end_model_i.m4(8'h0f);
    rdreg(OFF_M4_RX, 32'hc4);
    far_end_model_i.set(1'b1, 4'h5);
    far_end_model_i.m4(8'h0f);
    rdreg(OFF_M4_RX, 32'h0f);
    // Trinal option on the upper nibble
    wr(OFF_OPTION, 32'h1);
    far_end_model_i.m4(8'hf0);
    far_end_model_i.m4(8'hf0);
    rdreg(OFF_M4_RX, 32'h00);
    far_end_model_i.m4(8'hf0);
    rdreg(OFF_M4_RX, 32'hf0);
    wr(OFF_OPTION, 32'h0);
    // NT with deactivation request, dea received as zero
    wr(OFF_LINK_CTRL, 32'h14);
    far_end_model_i.m4(8'h80);
    cyc(3);
    chk(32'(controlled_deact), 32'h1);
    chk(32'(warm_start), 32'h1);
    // Full activation clears the warm start memory
    wr(OFF_LINK_CTRL, 32'h0);
    full_active <= 1'b1;
    cyc(2);
    chk(32'(warm_start), 32'h0);
    full_active <= 1'b0;
    // Received eoc, trinal then every frame
    wr(OFF_IRQ_EN, 32'h4);
    for (int i = 0; i < 2; i++)
      far_end_model_i.eoc(12'h123);
    rdreg(OFF_EOC, 32'hfff);
    far_end_model_i.eoc(12'h123);
    rdreg(OFF_EOC, 32'h123);
    wr(OFF_MAINT_MODE, 32'hf0);
    wr(OFF_IRQ_STAT, 32'h6);
    far_end_model_i.eoc(12'h123);
    cyc(3);
    rdreg(OFF_IRQ_STAT, 32'h4);
    chk(32'(irq), 32'h1);
    wr(OFF_IRQ_EN, 32'h0);
    cyc(2);
    chk(32'(irq), 32'h0);
    // Delta, then dual eoc
    wr(OFF_MAINT_MODE, 32'hb0);
    far_end_model_i.eoc(12'h456);
    rdreg(OFF_EOC, 32'h456);
    wr(OFF_MAINT_MODE, 32'h70);
    far_end_model_i.eoc(12'h789);
    rdreg(OFF_EOC, 32'h456);
    far_end_model_i.eoc(12'h789);
    rdreg(OFF_EOC, 32'h789);
    // Activation timeout, then with the timer disabled
    act_in_progress <= 1'b1;
    cyc(30);
    rdreg(OFF_LINK_STAT, 32'h7);
    act_in_progress <= 1'b0;
    wr(OFF_TIMER, 32'h1);
    act_in_progress <= 1'b1;
    cyc(30);
    rdreg(OFF_LINK_STAT, 32'h3);
    wrap_up;
  end
endmodule // test_maint_chan_ctrl
